// *** verilog/line_maintenance_control.sv ***
// line maintenance control bank: loop codes, error insertion, error counter, event masks
//
// What this block does
// R1: transmit code length field picks 5-8 bits
// R2: receive activate length field picks 5-8 bits
// R3: receive deactivate length field, reset selects 6
// R4: transmit loop code register, default 00001
// R5: receive activate code register, default 00001
// R6: receive deactivate code register, default 001001
// R7: rising violation bit inserts exactly one violation
// R8: rising logic-error bit inserts one pattern error
// R9: excess-zero rule select, 0 ANSI, 1 FCC
// R10: error source field chooses counted error kind
// R11: report mode bit, 0 manual, 1 automatic
// R12: rising transfer bit copies count, resets counter
// R13: mask bits 6-4 gate detect events, reset masked
// R14: mask bits 3-0 gate line alarms, reset masked
// R15: pattern 11 sends loop code, 10 PRBS
// R16: loop code repeats msb first without gaps
// R17: automatic mode transfers count every second tick
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "lmc_map.svh"

module line_maintenance_control (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata,
   input  wire logic [6:0]        line_events,
   input  wire lmc_pkg::err_in_s  err_in,
   input  wire logic              second_tick,
   input  wire logic              tx_bit_en,
   output logic                   tx_code_bit,
   output logic                   tx_loop_active,
   output logic                   tx_prbs_active,
   output logic                   violation_insert,
   output logic                   logic_error_insert,
   output logic                   excess_zero_rule_sel,
   output lmc_pkg::code_cfg_s     rx_activate_cfg,
   output lmc_pkg::code_cfg_s     rx_deactivate_cfg,
   output logic                   irq
);
   import lmc_pkg::*;

   state_s   s_q;
   state_s   s_d;
   logic     wr_ins;
   logic     trf_rise;
   logic     auto_trf;
   logic     count_inc;
   logic [2:0] msb_sel;
   err_src_e src;

   // outputs are plain flop fields
   assign rdata                = s_q.rdata;
   assign tx_code_bit          = s_q.tx_bit;
   assign tx_loop_active       = s_q.loop_active;
   assign tx_prbs_active       = s_q.prbs_active;
   assign violation_insert     = s_q.viol_pulse;
   assign logic_error_insert   = s_q.logic_pulse;
   // R9: rule select handed to the detector
   assign excess_zero_rule_sel = s_q.ins_ctrl[`INS_EXZ_RULE_BIT];
   // R2: activate code and length to the detector
   assign rx_activate_cfg      = {s_q.act_code, s_q.len_ctrl[`LEN_ACT_MSB:`LEN_ACT_LSB]};
   // R3: deactivate code and length to the detector
   assign rx_deactivate_cfg    = {s_q.deact_code, s_q.len_ctrl[`LEN_DEACT_MSB:`LEN_DEACT_LSB]};
   assign irq                  = s_q.irq;

   // next state of the whole bank
   always_comb begin
      s_d         = s_q;
      wr_ins      = wr && (addr == `OFS_INS_CTRL);
      src         = err_src_e'(s_q.ins_ctrl[`INS_SRC_MSB:`INS_SRC_LSB]);
      // R1: length code 00..11 maps to msb index 4..7
      msb_sel     = `MIN_CODE_BITS + {1'b0, s_q.len_ctrl[`LEN_TX_MSB:`LEN_TX_LSB]};
      // R12: only a 0 to 1 write of the transfer bit acts
      trf_rise    = wr_ins && wdata[`INS_TRF_BIT] && !s_q.ins_ctrl[`INS_TRF_BIT];
      // R17: timer expiry stands in for the write
      auto_trf    = second_tick && s_q.ins_ctrl[`INS_MODE_BIT];

      // R10: counted error source
      case (src)
         SRC_PRBS:   count_inc = err_in.prbs_err;
         SRC_EXZ:    count_inc = err_in.exz_err;
         SRC_CV:     count_inc = err_in.cv_err;
         SRC_CV_EXZ: count_inc = err_in.cv_err || err_in.exz_err;
         default:    count_inc = 1'b0;
      endcase

      // R7: single violation on a rising write of the bit
      s_d.viol_pulse  = wr_ins && wdata[`INS_VIOL_BIT] && !s_q.ins_ctrl[`INS_VIOL_BIT];
      // R8: single logic error on a rising write of the bit
      s_d.logic_pulse = wr_ins && wdata[`INS_LOGIC_BIT] && !s_q.ins_ctrl[`INS_LOGIC_BIT];

      // register writes; reserved bits are never stored
      if (wr) begin
         case (addr)
            `OFS_PATTERN_CTRL: begin
               s_d.pattern_ctrl = '0;
               s_d.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] = wdata[`PATTERN_MSB:`PATTERN_LSB];
            end
            `OFS_LEN_CTRL:    s_d.len_ctrl   = wdata & `LEN_CTRL_USED;
            `OFS_TX_CODE:     s_d.tx_code    = wdata;
            `OFS_ACT_CODE:    s_d.act_code   = wdata;
            `OFS_DEACT_CODE:  s_d.deact_code = wdata;
            `OFS_INS_CTRL:    s_d.ins_ctrl   = wdata & `INS_CTRL_USED;
            `OFS_EVENT_MASK:  s_d.mask       = wdata & `EVENT_USED;
            // write one to clear, a fresh event in the same cycle wins
            `OFS_EVENT_STATUS: s_d.status    = s_q.status & ~wdata;
            default: ;
         endcase
      end
      s_d.status = (s_d.status | {1'b0, line_events}) & `EVENT_USED;

      // R13: masked events never raise the line (mask 1 = masked)
      // R14: same gating for the alarm bits
      s_d.irq = |(s_d.status & ~s_d.mask);

      // R15: pattern decode kept in flops
      s_d.loop_active = (s_d.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] == PAT_LOOP);
      s_d.prbs_active = (s_d.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] == PAT_PRBS);

      // R12: copy and restart; an error in the same cycle is kept
      if (trf_rise || auto_trf) begin
         s_d.hold  = s_q.count;
         s_d.count = {15'h0000, count_inc};
      end else if (count_inc && s_q.count != `COUNT_MAX) begin
         // saturates rather than wrapping so an overrun stays visible
         s_d.count = s_q.count + 16'h0001;
      end

      // R16: msb of the selected bits first, wrap with no gap
      if (!s_q.loop_active) begin
         s_d.bit_idx = msb_sel;
      end else if (tx_bit_en) begin
         // R4: only the selected low bits of the code are sent
         s_d.tx_bit  = s_q.tx_code[s_q.bit_idx];
         s_d.bit_idx = (s_q.bit_idx == 3'h0) ? msb_sel : s_q.bit_idx - 3'h1;
      end

      // read data stands only in the cycle after the strobe
      s_d.rdata = 8'h00;
      if (rd) begin
         case (addr)
            `OFS_PATTERN_CTRL: s_d.rdata = s_q.pattern_ctrl;
            `OFS_LEN_CTRL:     s_d.rdata = s_q.len_ctrl;
            `OFS_TX_CODE:      s_d.rdata = s_q.tx_code;
            `OFS_ACT_CODE:     s_d.rdata = s_q.act_code;
            `OFS_DEACT_CODE:   s_d.rdata = s_q.deact_code;
            `OFS_INS_CTRL:     s_d.rdata = s_q.ins_ctrl;
            `OFS_EVENT_MASK:   s_d.rdata = s_q.mask;
            `OFS_EVENT_STATUS: s_d.rdata = s_q.status;
            `OFS_HOLD_LOW:     s_d.rdata = s_q.hold[7:0];
            `OFS_HOLD_HIGH:    s_d.rdata = s_q.hold[15:8];
            default:           s_d.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q              <= '0;
         s_q.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] <= `RST_PATTERN;
         // R1: transmit length 00, R2: activate 00, R3: deactivate 01
         s_q.len_ctrl     <= `RST_LEN_CTRL;
         // R4: transmit code 00001
         s_q.tx_code      <= `RST_TX_CODE;
         // R5: activate pattern 00001
         s_q.act_code     <= `RST_ACT_CODE;
         // R6: deactivate pattern 001001
         s_q.deact_code   <= `RST_DEACT_CODE;
         // R11: manual report mode after reset
         s_q.ins_ctrl     <= `RST_INS_CTRL;
         // R13: every mask bit set
         s_q.mask         <= `RST_EVENT_MASK;
         s_q.bit_idx      <= `MIN_CODE_BITS;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_viol_single_shot: assert property ( // R7
      violation_insert |=> !violation_insert)
      else $error("violation insert lasted more than one cycle");

   chk_viol_cause: assert property ( // R7
      violation_insert |-> $past(wr && addr == `OFS_INS_CTRL && wdata[`INS_VIOL_BIT]
                                 && !s_q.ins_ctrl[`INS_VIOL_BIT]))
      else $error("violation insert without a rising write");

   chk_logic_err_cause: assert property ( // R8
      logic_error_insert |-> $past(wr && addr == `OFS_INS_CTRL && wdata[`INS_LOGIC_BIT]
                                   && !s_q.ins_ctrl[`INS_LOGIC_BIT]) ##1 !logic_error_insert)
      else $error("logic error insert not a single caused pulse");

   chk_manual_transfer: assert property ( // R12
      (wr && addr == `OFS_INS_CTRL && wdata[`INS_TRF_BIT] && !s_q.ins_ctrl[`INS_TRF_BIT])
      |=> s_q.hold == $past(s_q.count) && s_q.count <= 16'h0001)
      else $error("transfer did not copy and clear the count");

   chk_auto_transfer: assert property ( // R17
      (second_tick && s_q.ins_ctrl[`INS_MODE_BIT])
      |=> s_q.hold == $past(s_q.count) && s_q.count <= 16'h0001)
      else $error("automatic transfer missed a timer tick");

   chk_loop_bit_order: assert property ( // R16
      (s_q.loop_active && tx_bit_en) |=> tx_code_bit == $past(s_q.tx_code[s_q.bit_idx]))
      else $error("loop code bit out of order");

   chk_irq_gating: assert property ( // R13
      irq == |(s_q.status & ~s_q.mask))
      else $error("interrupt disagrees with unmasked status");

   chk_event_sticky: assert property ( // R14
      (|line_events) |=> (s_q.status & {1'b0, $past(line_events)})
                         == {1'b0, $past(line_events)})
      else $error("event did not set its status bit");

   chk_pattern_decode: assert property ( // R15
      tx_prbs_active == (s_q.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] == PAT_PRBS)
      && tx_loop_active == (s_q.pattern_ctrl[`PATTERN_MSB:`PATTERN_LSB] == PAT_LOOP))
      else $error("pattern select decode wrong");

   chk_pattern_exclusive: assert property ( // R15
      !(tx_loop_active && tx_prbs_active))
      else $error("loop code and test pattern both selected");

   // loop code index: parked at the msb while idle, steps down, wraps
   chk_idx_parked: assert property ( // R1
      !s_q.loop_active |=> s_q.bit_idx == $past(msb_sel))
      else $error("idle bit index not at the selected msb");

   chk_idx_step: assert property ( // R16
      (s_q.loop_active && tx_bit_en && s_q.bit_idx != 3'h0)
      |=> s_q.bit_idx == $past(s_q.bit_idx) - 3'h1)
      else $error("bit index did not step down");

   chk_idx_wrap: assert property ( // R16
      (s_q.loop_active && tx_bit_en && s_q.bit_idx == 3'h0)
      |=> s_q.bit_idx == $past(msb_sel))
      else $error("bit index did not wrap to the msb");

   chk_bit_held: assert property ( // R16
      !(s_q.loop_active && tx_bit_en) |=> $stable(tx_code_bit))
      else $error("code bit changed without a strobe");

   chk_tx_len_write: assert property ( // R1
      (wr && addr == `OFS_LEN_CTRL)
      |=> s_q.len_ctrl[`LEN_TX_MSB:`LEN_TX_LSB] == $past(wdata[`LEN_TX_MSB:`LEN_TX_LSB]))
      else $error("transmit length not stored");

   chk_len_reserved: assert property ( // R1
      (s_q.len_ctrl & ~`LEN_CTRL_USED) == 8'h00)
      else $error("reserved length bits not zero");

   chk_len_readback: assert property ( // R1
      (rd && addr == `OFS_LEN_CTRL) |=> rdata == $past(s_q.len_ctrl))
      else $error("length register read back wrong");

   chk_act_len_write: assert property ( // R2
      (wr && addr == `OFS_LEN_CTRL)
      |=> rx_activate_cfg.len == $past(wdata[`LEN_ACT_MSB:`LEN_ACT_LSB]))
      else $error("activate length not handed over");

   chk_deact_len_write: assert property ( // R3
      (wr && addr == `OFS_LEN_CTRL)
      |=> rx_deactivate_cfg.len == $past(wdata[`LEN_DEACT_MSB:`LEN_DEACT_LSB]))
      else $error("deactivate length not handed over");

   chk_tx_code_write: assert property ( // R4
      (wr && addr == `OFS_TX_CODE) |=> s_q.tx_code == $past(wdata))
      else $error("transmit code not stored");

   chk_tx_code_held: assert property ( // R4
      !(wr && addr == `OFS_TX_CODE) |=> $stable(s_q.tx_code))
      else $error("transmit code changed without a write");

   chk_act_code_write: assert property ( // R5
      (wr && addr == `OFS_ACT_CODE) |=> rx_activate_cfg.code == $past(wdata))
      else $error("activate code not handed over");

   chk_act_code_held: assert property ( // R5
      !(wr && addr == `OFS_ACT_CODE) |=> $stable(rx_activate_cfg.code))
      else $error("activate code changed without a write");

   chk_deact_code_write: assert property ( // R6
      (wr && addr == `OFS_DEACT_CODE) |=> rx_deactivate_cfg.code == $past(wdata))
      else $error("deactivate code not handed over");

   chk_deact_code_held: assert property ( // R6
      !(wr && addr == `OFS_DEACT_CODE) |=> $stable(rx_deactivate_cfg.code))
      else $error("deactivate code changed without a write");

   chk_viol_fires: assert property ( // R7
      (wr && addr == `OFS_INS_CTRL && wdata[`INS_VIOL_BIT] && !s_q.ins_ctrl[`INS_VIOL_BIT])
      |=> violation_insert)
      else $error("rising violation bit gave no pulse");

   chk_viol_refused: assert property ( // R7
      (wr && addr == `OFS_INS_CTRL && s_q.ins_ctrl[`INS_VIOL_BIT]) |=> !violation_insert)
      else $error("violation inserted without clearing first");

   chk_logic_fires: assert property ( // R8
      (wr && addr == `OFS_INS_CTRL && wdata[`INS_LOGIC_BIT] && !s_q.ins_ctrl[`INS_LOGIC_BIT])
      |=> logic_error_insert)
      else $error("rising logic error bit gave no pulse");

   chk_logic_refused: assert property ( // R8
      (wr && addr == `OFS_INS_CTRL && s_q.ins_ctrl[`INS_LOGIC_BIT]) |=> !logic_error_insert)
      else $error("logic error inserted without clearing first");

   chk_exz_rule_write: assert property ( // R9
      (wr && addr == `OFS_INS_CTRL)
      |=> excess_zero_rule_sel == $past(wdata[`INS_EXZ_RULE_BIT]))
      else $error("excess zero rule not handed over");

   chk_src_both: assert property ( // R10
      (src == SRC_CV_EXZ && (err_in.cv_err || err_in.exz_err) && !trf_rise && !auto_trf
       && s_q.count != `COUNT_MAX) |=> s_q.count == $past(s_q.count) + 16'h0001)
      else $error("combined source error not counted");

   chk_src_prbs_only: assert property ( // R10
      (src == SRC_PRBS && !err_in.prbs_err && !trf_rise && !auto_trf)
      |=> $stable(s_q.count))
      else $error("counter moved without a pattern error");

   chk_manual_no_tick: assert property ( // R11
      (second_tick && !s_q.ins_ctrl[`INS_MODE_BIT] && !trf_rise) |=> $stable(s_q.hold))
      else $error("timer tick transferred in manual mode");

   chk_transfer_refused: assert property ( // R12
      (wr && addr == `OFS_INS_CTRL && s_q.ins_ctrl[`INS_TRF_BIT] && !auto_trf)
      |=> $stable(s_q.hold))
      else $error("transfer without clearing the bit first");

   chk_mask_write: assert property ( // R13
      (wr && addr == `OFS_EVENT_MASK) |=> s_q.mask == ($past(wdata) & `EVENT_USED))
      else $error("mask write not stored");

   chk_status_clear: assert property ( // R14
      (wr && addr == `OFS_EVENT_STATUS && !(|line_events))
      |=> (s_q.status & $past(wdata)) == 8'h00)
      else $error("status bit not cleared by a one");

endmodule

// *** verilog/lmc_map.svh ***
// register offsets, field positions and reset values of the line maintenance bank
`ifndef LMC_MAP_SVH
`define LMC_MAP_SVH

`define OFS_PATTERN_CTRL    8'h0A
`define OFS_LEN_CTRL        8'h0C
`define OFS_TX_CODE         8'h0D
`define OFS_ACT_CODE        8'h0E
`define OFS_DEACT_CODE      8'h0F
`define OFS_INS_CTRL        8'h10
`define OFS_EVENT_MASK      8'h11
`define OFS_EVENT_STATUS    8'h20
`define OFS_HOLD_LOW        8'h21
`define OFS_HOLD_HIGH       8'h22

`define RST_PATTERN         2'h0
`define RST_LEN_CTRL        8'h01
`define RST_TX_CODE         8'h01
`define RST_ACT_CODE        8'h01
`define RST_DEACT_CODE      8'h09
`define RST_INS_CTRL        8'h00
`define RST_EVENT_MASK      8'h7F

`define PATTERN_MSB         6
`define PATTERN_LSB         5
`define LEN_TX_MSB          5
`define LEN_TX_LSB          4
`define LEN_ACT_MSB         3
`define LEN_ACT_LSB         2
`define LEN_DEACT_MSB       1
`define LEN_DEACT_LSB       0
`define INS_VIOL_BIT        6
`define INS_LOGIC_BIT       5
`define INS_EXZ_RULE_BIT    4
`define INS_SRC_MSB         3
`define INS_SRC_LSB         2
`define INS_MODE_BIT        1
`define INS_TRF_BIT         0
`define LEN_CTRL_USED       8'h3F
`define INS_CTRL_USED       8'h7F
`define EVENT_USED          8'h7F

`define MIN_CODE_BITS       3'h4
`define COUNT_MAX           16'hFFFF

`endif

// *** verilog/lmc_pkg.sv ***
// types shared by the line maintenance bank
package lmc_pkg;

   typedef enum logic [1:0] {
      PAT_NORMAL = 2'b00,
      PAT_ONES   = 2'b01,
      PAT_PRBS   = 2'b10,
      PAT_LOOP   = 2'b11
   } pattern_e;

   typedef enum logic [1:0] {
      SRC_PRBS   = 2'b00,
      SRC_EXZ    = 2'b01,
      SRC_CV     = 2'b10,
      SRC_CV_EXZ = 2'b11
   } err_src_e;

   // repeating code and its length code (00..11 -> 5..8 bits)
   typedef struct packed {
      logic [7:0] code;
      logic [1:0] len;
   } code_cfg_s;

   typedef struct packed {
      logic prbs_err;
      logic exz_err;
      logic cv_err;
   } err_in_s;

   typedef struct packed {
      logic [7:0]  pattern_ctrl;
      logic [7:0]  len_ctrl;
      logic [7:0]  tx_code;
      logic [7:0]  act_code;
      logic [7:0]  deact_code;
      logic [7:0]  ins_ctrl;
      logic [7:0]  mask;
      logic [7:0]  status;
      logic [15:0] count;
      logic [15:0] hold;
      logic [7:0]  rdata;
      logic        irq;
      logic        viol_pulse;
      logic        logic_pulse;
      logic        loop_active;
      logic        prbs_active;
      logic [2:0]  bit_idx;
      logic        tx_bit;
   } state_s;

endpackage

// *** bench/test_line_maintenance_control.sv ***
// self-checking bench for the line maintenance control bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end

module test_line_maintenance_control;
   import lmc_pkg::*;
   localparam logic [7:0] RST_A [11] = '{8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
                                         8'h20, 8'h21, 8'h22, 8'h30};
   localparam logic [7:0] RST_V [11] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h09, 8'h00, 8'h7F,
                                         8'h00, 8'h00, 8'h00, 8'h00};
   logic        clk;
   logic        rst_n;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [6:0]  line_events;
   err_in_s     err_in;
   logic        second_tick;
   logic        tx_bit_en;
   logic        tx_code_bit;
   logic        loop_on;
   logic        prbs_on;
   logic        viol;
   logic        lerr;
   logic        exz_sel;
   code_cfg_s   act_cfg;
   code_cfg_s   deact_cfg;
   logic        irq;
   int          error_cnt;
   int          compares;
   int          cycles;
   logic [31:0] rnd;
   logic        rd_seen;
   logic [15:0] exp_q[$];   // {address, expected byte}, oldest first

   line_maintenance_control u_line_maintenance_control (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .line_events(line_events), .err_in(err_in),
      .second_tick(second_tick), .tx_bit_en(tx_bit_en), .tx_code_bit(tx_code_bit),
      .tx_loop_active(loop_on), .tx_prbs_active(prbs_on), .violation_insert(viol),
      .logic_error_insert(lerr), .excess_zero_rule_sel(exz_sel),
      .rx_activate_cfg(act_cfg), .rx_deactivate_cfg(deact_cfg), .irq(irq)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // expected byte is queued; the watcher compares it one cycle later
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back({a, e});
      @(posedge clk);
      rd   <= 1'b0;
   endtask

   task ins_chk(input logic v, input logic l);
      @(negedge clk);
      `CHK("violation_insert", v, viol)
      `CHK("logic_error_insert", l, lerr)
      @(negedge clk);
      `CHK("violation_insert", 1'b0, viol)
      `CHK("logic_error_insert", 1'b0, lerr)
   endtask

   // random error pulses; n counts those the selected source should see
   task errs(input int k, input logic [1:0] src, inout int n);
      logic [2:0] x;
      for (int i = 0; i < k; i++) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         x = rnd[2:0];
         err_in <= x;
         case (src)
            2'd0: n += x[2];
            2'd1: n += x[1];
            2'd2: n += x[0];
            default: n += x[0] | x[1];
         endcase
      end
      @(posedge clk);
      err_in <= '0;
   endtask

   task pulse(input int which, input logic [6:0] e);
      @(posedge clk);
      if (which == 0) second_tick <= 1'b1;
      else line_events <= e;
      @(posedge clk);
      second_tick <= 1'b0;
      line_events <= '0;
      @(negedge clk);
   endtask

   task complete_run;
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // read watcher: rdata stands only in the cycle after the strobe
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      if (rd_seen && exp_q.size() > 0) begin
         `CHK($sformatf("rdata at %h", exp_q[0][15:8]), exp_q[0][7:0], rdata)
         void'(exp_q.pop_front());
      end
   end

   // hang guard, several times the under one thousand cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         error_cnt++;
         complete_run;
      end
   end

   initial begin
      int n;
      int junk;
      logic [7:0] v;
      rst_n = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; line_events = '0;
      err_in = '0; second_tick = 1'b0; tx_bit_en = 1'b0; rnd = 32'h7E49;
      error_cnt = 0; compares = 0; cycles = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("act_cfg", {8'h01, 2'b00}, act_cfg)
      `CHK("deact_cfg", {8'h09, 2'b01}, deact_cfg)
      `CHK("exz_sel", 1'b0, exz_sel)
      for (int i = 0; i < 11; i++) rd_chk(RST_A[i], RST_V[i]);
      // random read-back of the length and mask registers, codes checked on the cfg ports
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         wr_reg(8'h0C, rnd[7:0]);
         wr_reg(8'h0E, rnd[15:8]);
         wr_reg(8'h0F, rnd[23:16]);
         wr_reg(8'h11, rnd[31:24]);
         rd_chk(8'h0C, rnd[7:0] & 8'h3F);
         rd_chk(8'h11, rnd[31:24] & 8'h7F);
         `CHK("act_cfg", {rnd[15:8], rnd[3:2]}, act_cfg)
         `CHK("deact_cfg", {rnd[23:16], rnd[1:0]}, deact_cfg)
      end
      // single insertions only on a rising bit
      wr_reg(8'h10, 8'h40);
      ins_chk(1'b1, 1'b0);
      wr_reg(8'h10, 8'h40);
      ins_chk(1'b0, 1'b0);
      wr_reg(8'h10, 8'h00);
      wr_reg(8'h10, 8'h60);
      ins_chk(1'b1, 1'b1);
      wr_reg(8'h10, 8'h10);
      ins_chk(1'b0, 1'b0);
      `CHK("exz_sel", 1'b1, exz_sel)
      // every error source, manual transfer, tick ignored
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'h10, {4'h0, s[1:0], 2'b00});
         wr_reg(8'h10, {4'h0, s[1:0], 2'b01});
         wr_reg(8'h10, {4'h0, s[1:0], 2'b00});
         n = 0;
         errs(12, s[1:0], n);
         pulse(0, 7'h00);
         wr_reg(8'h10, {4'h0, s[1:0], 2'b01});
         rd_chk(8'h21, n[7:0]);
         rd_chk(8'h22, 8'h00);
         errs(5, s[1:0], junk);
         wr_reg(8'h10, {4'h0, s[1:0], 2'b01});
         rd_chk(8'h21, n[7:0]);
      end
      // automatic report on the second tick
      wr_reg(8'h10, 8'h02);
      pulse(0, 7'h00);
      n = 0;
      errs(12, 2'd0, n);
      pulse(0, 7'h00);
      rd_chk(8'h21, n[7:0]);
      wr_reg(8'h0A, 8'h40);
      @(negedge clk);
      `CHK("prbs_active", 1'b1, prbs_on)
      `CHK("loop_active", 1'b0, loop_on)
      for (int l = 0; l < 4; l++) begin
         rnd = lfsr(rnd);
         v = (l == 0) ? 8'h01 : rnd[7:0];
         wr_reg(8'h0A, 8'h00);
         wr_reg(8'h0C, {2'b00, l[1:0], 4'h0});
         wr_reg(8'h0D, v);
         rd_chk(8'h0D, v);
         wr_reg(8'h0A, 8'h60);
         @(posedge clk);
         tx_bit_en <= 1'b1;
         for (int i = 0; i < 2 * (l + 5); i++) begin
            @(posedge clk);
            @(negedge clk);
            `CHK("loop_active", 1'b1, loop_on)
            `CHK("code_bit", v[l + 4 - i % (l + 5)], tx_code_bit)
         end
         @(posedge clk);
         tx_bit_en <= 1'b0;
      end
      // masked events stay silent but still latch
      wr_reg(8'h11, 8'h7F);
      pulse(1, 7'h7F);
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h20, 8'h7F);
      wr_reg(8'h20, 8'h7F);
      rd_chk(8'h20, 8'h00);
      for (int b = 0; b < 7; b++) begin
         wr_reg(8'h11, ~(8'h01 << b) & 8'h7F);
         pulse(1, 7'h01 << b);
         `CHK("irq", 1'b1, irq)
         wr_reg(8'h20, 8'h01 << b);
         @(negedge clk);
         `CHK("irq", 1'b0, irq)
      end
      repeat (3) @(posedge clk);
      complete_run;
   end
endmodule
